// *** rtl/twe_defs.vh ***
// Constants of the two-wire event and acknowledge control block
// Assumes inclusion by bare name from the block's design file
`ifndef TWE_DEFS_VH
`define TWE_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define TWE_A_CTL 4'h0
`define TWE_A_DAT 4'h4
`define TWE_A_STA 4'h8
`define TWE_A_ADR 4'hc

// ----------------------------------------
// Control and address field positions
// ----------------------------------------
`define TWE_B_AA 3
`define TWE_B_EVT 4
`define TWE_B_STO 5
`define TWE_B_STA 6
`define TWE_B_EN 7
`define TWE_B_GC 0

// ----------------------------------------
// Reset values and bus answers
// ----------------------------------------
`define TWE_RST_BYTE 8'h00
`define TWE_RESP_OK 2'b00
`define TWE_RESP_ERR 2'b10

// ----------------------------------------
// Clock and bit rates in Hz
// ----------------------------------------
`define TWE_CLK_HZ 200000000
`define TWE_RATE0_HZ 100000
`define TWE_RATE1_HZ 3750
`define TWE_RATE2_HZ 150000
`define TWE_RATE3_HZ 200000
`define TWE_RATE4_HZ 25000
`define TWE_RATE5_HZ 1875
`define TWE_RATE6_HZ 37500
`define TWE_RATE7_HZ 50000

// ----------------------------------------
// Status codes
// ----------------------------------------
`define TWE_ST_START 8'h08
`define TWE_ST_RSTART 8'h10
`define TWE_ST_MT_ACK 8'h18
`define TWE_ST_MT_NACK 8'h20
`define TWE_ST_ARB 8'h38
`define TWE_ST_MR_ACK 8'h50
`define TWE_ST_MR_NACK 8'h58
`define TWE_ST_SR_ADDR 8'h60
`define TWE_ST_SR_GC 8'h70
`define TWE_ST_SR_DATA 8'h80
`define TWE_ST_SR_STOP 8'ha0
`define TWE_ST_ST_ADDR 8'ha8
`define TWE_ST_ST_ACK 8'hb8
`define TWE_ST_ST_NACK 8'hc0
`define TWE_ST_IDLE 8'hf8

`endif

// *** rtl/twe_event_ack.v ***
// Two-wire serial interface: event flag, acknowledge control, bus engine
// Assumes AXI4-Lite master on clk and open-drain SCL/SDA resolved outside
//
// Summary of operation
// - Event flag set after own START generated
// - Event on own address with acknowledge enabled
// - Event on general call when both enables set
// - Master: event after every byte, even lost
// - Addressed slave: event after every byte
// - Addressed slave: event on STOP or START
// - Interrupt request follows the event flag
// - Event flag holds SCL low while busy as master, slave in address phase or addressed slave; transfer waits
// - Acknowledge own address when enabled
// - Acknowledge general call when both enabled
// - Master receiver acknowledges bytes when enabled
// - Slave receiver acknowledges bytes when enabled
// - Acknowledge disabled: never drive acknowledge
// - Acknowledge disabled: no address interrupt
// - Start request: START when free, repeated as master, else waits
// - Stop request: as master sends STOP and STOP clears it; as slave cleared with no STOP
// - Three-bit field selects the bit rate
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "twe_defs.vh"

module twe_event_ack #(
  parameter CLK_HZ = `TWE_CLK_HZ,
  parameter ADDR_W = 4
) (
  // Clock, reset, enable
  input wire clk,
  input wire rst,
  input wire ce,
  // AXI4-Lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Bus pins, open drain
  input wire scl_i,
  output reg scl_o,
  output reg scl_oe_n,
  input wire sda_i,
  output reg sda_o,
  output reg sda_oe_n,
  // Interrupt request
  output reg irq
);

  localparam [5:0] S_IDLE = 6'b000001;
  localparam [5:0] S_STA = 6'b000010;
  localparam [5:0] S_BYTE = 6'b000100;
  localparam [5:0] S_WAIT = 6'b001000;
  localparam [5:0] S_RST = 6'b010000;
  localparam [5:0] S_STO = 6'b100000;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Half bit period minus one; rounds up so the rate is never exceeded
  function [15:0] half_cnt;
    input [2:0] c;
    reg [31:0] r;
    reg [31:0] q;
    begin
      case (c)
        3'h0: r = `TWE_RATE0_HZ;
        3'h1: r = `TWE_RATE1_HZ;
        3'h2: r = `TWE_RATE2_HZ;
        3'h3: r = `TWE_RATE3_HZ;
        3'h4: r = `TWE_RATE4_HZ;
        3'h5: r = `TWE_RATE5_HZ;
        3'h6: r = `TWE_RATE6_HZ;
        default: r = `TWE_RATE7_HZ;
      endcase
      q = (CLK_HZ + 2 * r - 1) / (2 * r) - 1;
      half_cnt = q[15:0];
    end
  endfunction

  function mapped;
    input [ADDR_W-1:0] a;
    begin
      mapped = (a == `TWE_A_CTL) || (a == `TWE_A_DAT) ||
               (a == `TWE_A_STA) || (a == `TWE_A_ADR);
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg [7:0] ctl_q, dat_q, sta_q, own_q;
  reg aw_ok_q, w_ok_q, wst_q;
  reg [ADDR_W-1:0] wa_q;
  reg [7:0] wd_q;
  reg scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  reg [5:0] st_q;
  reg [1:0] ph_q;
  reg [15:0] tmr_q;
  reg mscl_q, sda_q, master_q, busy_q, rs_q, evt_p_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg mfirst_q, mrx_q, lost_q, aph_q, adr_q, stx_q, hit_q, gc_q;
  reg ackd_q, nack_q;
  reg [7:0] rd_d;
  reg ev;
  reg [7:0] code;

  wire en = ctl_q[`TWE_B_EN];
  wire aa = ctl_q[`TWE_B_AA];
  wire evt = ctl_q[`TWE_B_EVT];
  wire [15:0] half = half_cnt(ctl_q[2:0]);
  wire tdone = (tmr_q == 16'h0000);
  wire rise = scl_s_q & ~scl_p_q;
  wire fall = ~scl_s_q & scl_p_q;
  wire sta_det = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire sto_det = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire act = master_q | lost_q | aph_q | adr_q;
  wire tx = master_q ? (mfirst_q | ~mrx_q) : (adr_q & stx_q);
  wire amatch = (sh_q[7:1] == own_q[7:1]);
  wire gmatch = own_q[`TWE_B_GC] & (sh_q[7:1] == 7'h00);
  wire hit_w = aa & (amatch | gmatch);
  wire bend = en & act & fall & (cnt_q == 4'h9);
  wire hold = evt & busy_q & act;
  wire wr_en = aw_ok_q & w_ok_q & ~s_axi_bvalid;

  // ----------------------------------------
  // Event source and status code
  // ----------------------------------------
  always @* begin
    ev = 1'b1;
    code = `TWE_ST_IDLE;
    if (en && st_q == S_STA && tdone) begin
      code = rs_q ? `TWE_ST_RSTART : `TWE_ST_START;
    end else if (bend && lost_q) begin
      code = `TWE_ST_ARB;
    end else if (bend && master_q) begin
      if (tx)
        code = nack_q ? `TWE_ST_MT_NACK : `TWE_ST_MT_ACK;
      else
        code = ackd_q ? `TWE_ST_MR_ACK : `TWE_ST_MR_NACK;
    end else if (bend && aph_q && hit_q) begin
      if (stx_q)
        code = `TWE_ST_ST_ADDR;
      else
        code = gc_q ? `TWE_ST_SR_GC : `TWE_ST_SR_ADDR;
    end else if (bend && adr_q) begin
      if (stx_q)
        code = nack_q ? `TWE_ST_ST_NACK : `TWE_ST_ST_ACK;
      else
        code = `TWE_ST_SR_DATA;
    end else if (en && adr_q && (sta_det || sto_det)) begin
      code = `TWE_ST_SR_STOP;
    end else begin
      ev = 1'b0;
    end
  end

  // ----------------------------------------
  // Register read decode
  // ----------------------------------------
  always @* begin
    if (s_axi_araddr == `TWE_A_CTL)
      rd_d = ctl_q;
    else if (s_axi_araddr == `TWE_A_DAT)
      rd_d = dat_q;
    else if (s_axi_araddr == `TWE_A_STA)
      rd_d = sta_q;
    else if (s_axi_araddr == `TWE_A_ADR)
      rd_d = own_q;
    else
      rd_d = 8'h00;
  end

  // ----------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TWE_RESP_OK;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TWE_RESP_OK;
      aw_ok_q <= 1'b0;
      w_ok_q <= 1'b0;
      wa_q <= {ADDR_W{1'b0}};
      wd_q <= 8'h00;
      wst_q <= 1'b0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok_q <= 1'b1;
        wa_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok_q <= 1'b1;
        wd_q <= s_axi_wdata[7:0];
        wst_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_en) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wa_q) ? `TWE_RESP_OK : `TWE_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        aw_ok_q <= 1'b0;
        w_ok_q <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_d};
        s_axi_rresp <= mapped(s_axi_araddr) ? `TWE_RESP_OK : `TWE_RESP_ERR;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Registers and bus engine
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_q <= `TWE_RST_BYTE;
      dat_q <= `TWE_RST_BYTE;
      sta_q <= `TWE_ST_IDLE;
      own_q <= `TWE_RST_BYTE;
      {scl_m_q, scl_s_q, scl_p_q} <= 3'b111;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'b111;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      scl_oe_n <= 1'b1;
      sda_oe_n <= 1'b1;
      irq <= 1'b0;
      st_q <= S_IDLE;
      ph_q <= 2'h0;
      tmr_q <= 16'h0000;
      {mscl_q, sda_q, master_q, busy_q, rs_q, evt_p_q} <= 6'h00;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      {mfirst_q, mrx_q, lost_q, aph_q, adr_q, stx_q, hit_q, gc_q} <= 8'h00;
      ackd_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (ce) begin
      // Pins pass two flops before any logic looks at them
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      scl_oe_n <= ~(mscl_q | hold);
      sda_oe_n <= ~sda_q;
      irq <= evt;
      evt_p_q <= evt;
      if (sta_det)
        busy_q <= 1'b1;
      else if (sto_det)
        busy_q <= 1'b0;
      // Software writes; writing 0 to the event bit is its only clear
      if (wr_en && wst_q) begin
        if (wa_q == `TWE_A_CTL)
          ctl_q <= {wd_q[7:5], wd_q[4] & evt, wd_q[3:0]};
        else if (wa_q == `TWE_A_DAT)
          dat_q <= wd_q;
        else if (wa_q == `TWE_A_ADR)
          own_q <= wd_q;
      end
      // Hardware set is ordered last so it wins over a same-cycle clear
      if (ev) begin
        ctl_q[`TWE_B_EVT] <= 1'b1;
        sta_q <= code;
      end
      if (bend)
        dat_q <= sh_q;
      if (sto_det)
        ctl_q[`TWE_B_STO] <= 1'b0;
      if (!en) begin
        st_q <= S_IDLE;
        {mscl_q, sda_q, master_q, lost_q, aph_q, adr_q} <= 6'h00;
        cnt_q <= 4'h0;
      end else begin
        if (sta_det) begin
          cnt_q <= 4'h0;
          // Own START is not an address phase
          if (!master_q && st_q == S_IDLE) begin
            aph_q <= 1'b1;
            adr_q <= 1'b0;
          end
        end
        if (sto_det) begin
          aph_q <= 1'b0;
          adr_q <= 1'b0;
          master_q <= 1'b0;
        end
        // Slave recovery: no STOP on the wire, just let go
        if (ctl_q[`TWE_B_STO] && !master_q && st_q == S_IDLE) begin
          ctl_q[`TWE_B_STO] <= 1'b0;
          {aph_q, adr_q, lost_q, sda_q} <= 4'h0;
          cnt_q <= 4'h0;
        end
        // Bit engine, shared by master and slave roles
        if (act && rise) begin
          cnt_q <= cnt_q + 4'h1;
          if (cnt_q < 4'h8)
            sh_q <= {sh_q[6:0], sda_s_q};
          else
            nack_q <= sda_s_q;
          // STOP and repeated START setup pull SDA on purpose: no loss there
          if (cnt_q < 4'h8 && master_q && st_q == S_BYTE && tx && sh_q[7] && !sda_s_q) begin
            lost_q <= 1'b1;
            {master_q, sda_q, mscl_q} <= 3'b000;
          end
        end
        if (act && fall) begin
          if (cnt_q < 4'h8) begin
            sda_q <= tx & ~sh_q[7];
          end else if (cnt_q == 4'h8) begin
            if (aph_q) begin
              hit_q <= hit_w;
              gc_q <= gmatch & ~amatch;
              stx_q <= sh_q[0];
              sda_q <= hit_w;
              if (!hit_w)
                aph_q <= 1'b0;
            end else begin
              sda_q <= ~tx & aa;
              ackd_q <= ~tx & aa;
            end
          end else begin
            sda_q <= 1'b0;
            cnt_q <= 4'h0;
            lost_q <= 1'b0;
            if (master_q) begin
              mfirst_q <= 1'b0;
              if (mfirst_q)
                mrx_q <= sh_q[0];
            end
            if (aph_q) begin
              aph_q <= 1'b0;
              adr_q <= hit_q;
            end
            if (adr_q && stx_q && nack_q)
              adr_q <= 1'b0;
          end
        end
        // Data byte goes out once software releases the event
        if (evt_p_q && !evt) begin
          sh_q <= dat_q;
          if (tx)
            sda_q <= ~dat_q[7];
        end
        // Master sequencer
        case (st_q)
          S_IDLE: begin
            if (ctl_q[`TWE_B_STA] && !busy_q && !evt) begin
              st_q <= S_STA;
              sda_q <= 1'b1;
              tmr_q <= half;
              rs_q <= 1'b0;
            end
          end
          S_STA: begin
            if (tdone) begin
              mscl_q <= 1'b1;
              master_q <= 1'b1;
              mfirst_q <= 1'b1;
              cnt_q <= 4'h0;
              ctl_q[`TWE_B_STA] <= 1'b0;
              st_q <= S_WAIT;
            end else begin
              tmr_q <= tmr_q - 16'h0001;
            end
          end
          S_WAIT: begin
            if (!evt) begin
              ph_q <= 2'h0;
              tmr_q <= half;
              if (ctl_q[`TWE_B_STO]) begin
                st_q <= S_STO;
                sda_q <= 1'b1;
              end else if (ctl_q[`TWE_B_STA]) begin
                st_q <= S_RST;
                sda_q <= 1'b0;
              end else begin
                st_q <= S_BYTE;
              end
            end
          end
          S_BYTE: begin
            // Timer only runs while SCL matches intent: slaves may stretch
            if (mscl_q || scl_s_q) begin
              if (tdone) begin
                mscl_q <= ~mscl_q;
                tmr_q <= half;
              end else begin
                tmr_q <= tmr_q - 16'h0001;
              end
            end
          end
          S_RST, S_STO: begin
            if (ph_q == 2'h0 || scl_s_q) begin
              if (!tdone) begin
                tmr_q <= tmr_q - 16'h0001;
              end else if (ph_q == 2'h0) begin
                mscl_q <= 1'b0;
                ph_q <= 2'h1;
                tmr_q <= half;
              end else if (st_q == S_RST) begin
                st_q <= S_STA;
                sda_q <= 1'b1;
                tmr_q <= half;
                rs_q <= 1'b1;
              end else begin
                sda_q <= 1'b0;
                ph_q <= 2'h2;
              end
            end
            if (st_q == S_STO && sto_det)
              st_q <= S_IDLE;
          end
          default: st_q <= S_IDLE;
        endcase
        if (bend && master_q)
          st_q <= S_WAIT;
        if (lost_q && st_q != S_IDLE)
          st_q <= S_IDLE;
      end
    end
  end

endmodule // twe_event_ack
`default_nettype wire

// *** verif/twe_event_ack_properties.sv ***
// Checker: register bus handshakes, event hold, SCL hold
// Assumes bind onto twe_event_ack, one clock domain
`timescale 1ns/10ps
`default_nettype none
module twe_event_ack_props (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins
  input wire logic scl_oe_n,
  input wire logic irq
);
  // --------
  // Properties
  // --------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_resp_a: assert property (wr_take |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && !s_axi_bvalid)
    else $error("write path not reopened");
  rd_resp_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  // Only a register write may end the request
  irq_hold_a: assert property ($fell(irq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("request ended without a write");
  scl_keep_a: assert property (irq && !scl_oe_n |=> !scl_oe_n || !irq)
    else $error("clock line let go early");
endmodule // twe_event_ack_props
`default_nettype wire

// *** verif/twe_bus_partner.sv ***
// Far side of the two-wire bus: acknowledging slave, addressing master
// Assumes the bench resolves scl and sda with pull-ups
`timescale 1ns/10ps
`default_nettype none
module twe_bus_partner (
  // Resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-downs onto the wires
  output logic scl_dn = 1'b0,
  output logic sda_dn = 1'b0
);
  // --------
  // Slave side
  // --------
  logic sl_en = 1'b0;
  logic stop_seen = 1'b0;
  logic busy = 1'b0;
  int nbit = 0;
  always @(negedge sda) if (scl) begin
    busy = 1'b1;
    nbit = 0;
  end
  always @(posedge sda) if (scl) begin
    busy = 1'b0;
    stop_seen = 1'b1;
  end
  // Ack only the address byte; later bytes are not modelled
  always @(negedge scl) if (busy && sl_en) begin
    nbit = nbit + 1;
    sda_dn = (nbit == 9);
  end
  // --------
  // Master side, 64 ns clock
  // --------
  task automatic send(input logic [7:0] b, output logic ack);
    sda_dn = 1'b1;
    #16 scl_dn = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      #16 sda_dn = !b[i];
      #16 scl_dn = 1'b0;
      wait (scl);
      #32 scl_dn = 1'b1;
    end
    #16 sda_dn = 1'b0;
    #16 scl_dn = 1'b0;
    wait (scl);
    #16 ack = sda;
    #16 scl_dn = 1'b1;
  endtask
  // Waits out any stretch before letting SDA rise
  task automatic stop;
    #16 sda_dn = 1'b1;
    #16 scl_dn = 1'b0;
    wait (scl);
    #16 sda_dn = 1'b0;
    #32;
  endtask
endmodule // twe_bus_partner
`default_nettype wire

// *** verif/tb.sv ***
// Testbench: registers, master start and byte, slave addressing
// Assumes design, partner and checker compiled first
`timescale 1ns/10ps
`default_nettype none
`include "twe_defs.vh"
module tb;
  // --------
  // Signals
  // --------
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  wire awready, wready, bvalid, arready, rvalid, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire scl_o, scl_oe_n, sda_o, sda_oe_n, scl_dn, sda_dn;
  wire scl = !((!scl_oe_n && !scl_o) || scl_dn);
  wire sda = !((!sda_oe_n && !sda_o) || sda_dn);
  int n_mismatch = 0;
  int compares = 0;
  logic ack;
  localparam logic [4:0] A_CTL = {1'b0, `TWE_A_CTL};
  localparam logic [4:0] A_DAT = {1'b0, `TWE_A_DAT};
  localparam logic [4:0] A_STA = {1'b0, `TWE_A_STA};
  localparam logic [4:0] A_ADR = {1'b0, `TWE_A_ADR};
  localparam logic [7:0] EN = 8'h01 << `TWE_B_EN;
  localparam logic [7:0] AA = 8'h01 << `TWE_B_AA;
  localparam logic [7:0] START_REQUEST = 8'h01 << `TWE_B_STA;
  localparam logic [7:0] STOP_REQUEST = 8'h01 << `TWE_B_STO;
  localparam logic [1:0] OK = `TWE_RESP_OK;
  localparam logic [1:0] ERR = `TWE_RESP_ERR;
  always #2.5 clk = ~clk;
  // Short rate count: half bit is 10 clocks at code 000
  twe_event_ack #(.CLK_HZ(2000000), .ADDR_W(5)) dut (
    .clk, .rst, .ce(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .scl_i(scl), .scl_o, .scl_oe_n, .sda_i(sda), .sda_o, .sda_oe_n, .irq);
  twe_bus_partner bus (.scl, .sda, .scl_dn, .sda_dn);
  // --------
  // Tasks
  // --------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    chk(bresp, er);
    bready <= 1'b0;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    chk(rresp, er);
    chk(rdata, {24'h000000, v});
    rready <= 1'b0;
  endtask
  // Skips two edges so a flag just cleared is not taken as new
  task automatic wait_irq(input int n);
    repeat (2) @(posedge clk);
    for (int i = 0; i < n && irq !== 1'b1; i++) @(posedge clk);
  endtask
  task automatic t_regs;
    rdc(A_CTL, 8'h00, OK);
    rdc(A_DAT, 8'h00, OK);
    rdc(A_ADR, 8'h00, OK);
    rdc(A_STA, `TWE_ST_IDLE, OK);
    rdc(5'h10, 8'h00, ERR);
    wr(5'h10, 8'h5a, ERR);
    wr(A_STA, 8'h5a, OK);
    rdc(A_STA, `TWE_ST_IDLE, OK);
    wr(A_DAT, 8'ha5, OK);
    wstrb <= 4'h0;
    wr(A_DAT, 8'h3c, OK);
    wstrb <= 4'hf;
    rdc(A_DAT, 8'ha5, OK);
  endtask
  task automatic t_master;
    bus.sl_en = 1'b1;
    wr(A_CTL, EN | START_REQUEST, OK);
    wait_irq(200);
    chk(irq, 1'b1);
    chk(scl_oe_n, 1'b0);
    chk({scl_o, sda_o}, 2'b00);
    rdc(A_STA, `TWE_ST_START, OK);
    repeat (40) @(posedge clk);
    chk(irq, 1'b1);
    wr(A_DAT, 8'h54, OK);
    wr(A_CTL, EN, OK);
    wait_irq(600);
    chk(irq, 1'b1);
    rdc(A_STA, `TWE_ST_MT_ACK, OK);
    rdc(A_DAT, 8'h54, OK);
    bus.stop_seen = 1'b0;
    wr(A_CTL, EN | STOP_REQUEST, OK);
    repeat (100) @(posedge clk);
    rdc(A_CTL, EN, OK);
    chk(bus.stop_seen, 1'b1);
    bus.sl_en = 1'b0;
  endtask
  task automatic slave_try(input logic [7:0] adr, input logic [7:0] c, input logic [7:0] b,
                           input logic ea, input logic [7:0] es);
    wr(A_ADR, adr, OK);
    wr(A_CTL, c, OK);
    bus.send(b, ack);
    chk(ack, ea);
    wait_irq(60);
    chk(irq, es != 8'h00);
    if (es != 8'h00) begin
      chk(scl_oe_n, 1'b0);
      rdc(A_STA, es, OK);
      wr(A_CTL, c, OK);
      bus.send(8'hc3, ack);
      chk(ack, 1'b0);
      wait_irq(60);
      chk(irq, 1'b1);
      rdc(A_STA, `TWE_ST_SR_DATA, OK);
      rdc(A_DAT, 8'hc3, OK);
      wr(A_CTL, c, OK);
    end
    bus.stop();
    if (es != 8'h00) begin
      wait_irq(60);
      rdc(A_STA, `TWE_ST_SR_STOP, OK);
      wr(A_CTL, c, OK);
    end
    repeat (20) @(posedge clk);
  endtask
  task automatic t_addressing;
    slave_try(8'h54, EN | AA, 8'h54, 1'b0, `TWE_ST_SR_ADDR);
    slave_try(8'h55, EN | AA, 8'h00, 1'b0, `TWE_ST_SR_GC);
    slave_try(8'h54, EN | AA, 8'h00, 1'b1, 8'h00);
    slave_try(8'h55, EN, 8'h54, 1'b1, 8'h00);
    bus.stop_seen = 1'b0;
    wr(A_CTL, EN | STOP_REQUEST, OK);
    rdc(A_CTL, EN, OK);
    repeat (20) @(posedge clk);
    chk(bus.stop_seen, 1'b0);
  endtask
  task automatic give_verdict;
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // --------
  // Run
  // --------
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_master;
    t_addressing;
    give_verdict;
  end
  // Whole run needs a few thousand clocks
  initial begin
    #100000;
    n_mismatch++;
    give_verdict;
  end
endmodule // tb
bind twe_event_ack twe_event_ack_props u_props (.clk, .rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .scl_oe_n, .irq);
`default_nettype wire
